// *** verilog/apr_regs.sv ***
// Overview of operation
// - Second accumulator takes ALU results when the pointer selects it, else plain register.
// - Third accumulator holds 16 bits; ALU target only when the pointer selects it.
// - Third accumulator decodes at subindex 03h of register module 09h.
// - Third accumulator and prefix clear to 0000h on every reset.
// - Prefix is 8 bits at subindexes 00h to 07h of module 0Bh, freely read/written.
// - Written prefix feeds the next instruction's high byte once, then clears itself.
// - Unloaded prefix reads zero; its upper eight bits always read zero.
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module apr_regs (
  input wire logic sys_clk, // Core clock, 25 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire apr_pkg::apr_bus_req_t busReq, // Register bus request.
  output logic [`APR_DATA_W-1:0] rdData, // Read data, valid the cycle after rd.
  input wire apr_pkg::apr_alu_t alu, // Execution unit port.
  output logic [`APR_DATA_W-1:0] accOut, // Selected accumulator, registered.
  output logic accOutValid, // Pointer selects an accumulator held here.
  output logic [`APR_DATA_W-1:0] acc2Value, // Second accumulator contents.
  output logic [`APR_DATA_W-1:0] acc3Value, // Third accumulator contents.
  output logic [`APR_PFX_LO_MSB:0] pfxHigh, // High byte offered to 8-bit sources.
  output logic pfxActive, // Prefix applies to the current instruction.
  output logic [`APR_PFX_EXT_MSB:0] pfxExt // Index extension bits of last prefix load.
);
  import apr_pkg::*;

  // Decode of a register address into one of the targets held here.
  // Address map: 92h second accumulator, 93h third, B0h to B7h prefix. Any
  // other address is not held here; a write to it is dropped and a read
  // returns zero, so the bus never has to wait for a slow decode.
  function automatic apr_sel_t decodeAddr(input logic [`APR_ADDR_W-1:0] a);
    logic [`APR_MOD_MSB-`APR_MOD_LSB:0] modIdx;
    logic [`APR_SUB_MSB-`APR_SUB_LSB:0] subIdx;
    modIdx = a[`APR_MOD_MSB:`APR_MOD_LSB];
    subIdx = a[`APR_SUB_MSB:`APR_SUB_LSB];
    if (modIdx == `APR_MOD_ACC && subIdx == `APR_SUB_ACC2) begin
      decodeAddr = APR_SEL_ACC2;
    end else if (modIdx == `APR_MOD_ACC && subIdx == `APR_SUB_ACC3) begin
      decodeAddr = APR_SEL_ACC3;
    end else if (modIdx == `APR_MOD_PFX && subIdx <= `APR_SUB_PFX_MAX) begin
      decodeAddr = APR_SEL_PFX;
    end else begin
      decodeAddr = APR_SEL_NONE;
    end
  endfunction

  // Decode of the accumulator pointer; used for write-back and for the read port.
  // Pointer codes other than these two belong to accumulators elsewhere in the
  // bank, so this block neither stores nor presents anything for them.
  function automatic apr_sel_t decodePtr(input logic [`APR_PTR_W-1:0] p);
    if (p == `APR_PTR_ACC2) begin
      decodePtr = APR_SEL_ACC2;
    end else if (p == `APR_PTR_ACC3) begin
      decodePtr = APR_SEL_ACC3;
    end else begin
      decodePtr = APR_SEL_NONE;
    end
  endfunction

  apr_sel_t busSel;
  apr_sel_t ptrSel;
  logic busWr;
  logic busRd;
  logic pfxLoad;
  logic [`APR_DATA_W-1:0] pfxValue;

  // Bus and pointer decode, shared by the accumulator, prefix and read data groups below.
  // The strobes are one-cycle pulses that never come together, so no priority
  // between a read and a write is needed here.
  always_comb begin
    busSel = decodeAddr(busReq.addr);
    ptrSel = decodePtr(alu.accPtr);
    busWr = busReq.wr;
    busRd = busReq.rd;
    pfxLoad = busWr && (busSel == APR_SEL_PFX);
  end

  // Accumulator group.
  logic [`APR_DATA_W-1:0] acc2, next_acc2;
  logic [`APR_DATA_W-1:0] acc3, next_acc3;

  // A result lands in an accumulator only while the pointer names it; otherwise
  // the register keeps whatever software last put there. A bus write in the
  // same cycle wins, since software addressing a register explicitly is taken
  // as the stronger intent.
  always_comb begin
    next_acc2 = acc2;
    next_acc3 = acc3;
    if (alu.resultWe && ptrSel == APR_SEL_ACC2) begin
      next_acc2 = alu.result;
    end
    if (alu.resultWe && ptrSel == APR_SEL_ACC3) begin
      next_acc3 = alu.result;
    end
    if (busWr && busSel == APR_SEL_ACC2) begin
      next_acc2 = busReq.wdata;
    end
    if (busWr && busSel == APR_SEL_ACC3) begin
      next_acc3 = busReq.wdata;
    end
  end

  // Accumulator registers.
  // Both clear on every reset, so no stale result survives into the first instruction.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc2 <= `APR_ACC_RESET;
      acc3 <= `APR_ACC_RESET;
    end else begin
      acc2 <= next_acc2;
      acc3 <= next_acc3;
    end
  end

  // Prefix register lives in its own unit; subindexes 00h to 07h of its module load it.
  // The low address bits travel with the load because subindexes above zero act
  // as index extension bits for the next instruction; they clear with the byte.
  apr_prefix_unit prefixUnit (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .loadEn(pfxLoad),
    .loadData(busReq.wdata),
    .loadSub(busReq.addr[`APR_PFX_EXT_MSB:0]),
    .instrDone(alu.instrDone),
    .pfxValue(pfxValue),
    .pfxActive(pfxActive),
    .pfxExt(pfxExt)
  );

  // Read data group.
  logic [`APR_DATA_W-1:0] next_rdData;

  // Read data hold only in the cycle after the strobe and drop to zero after,
  // so a stale word is never mistaken for a fresh one. Unmapped reads give zero.
  // An armed prefix that has not yet gone live reads back its stored byte, so
  // software sees the low byte it wrote.
  always_comb begin
    next_rdData = `APR_RD_RESET;
    if (busRd) begin
      unique case (busSel)
        APR_SEL_ACC2: begin
          next_rdData = acc2;
        end
        APR_SEL_ACC3: begin
          next_rdData = acc3;
        end
        APR_SEL_PFX: begin
          next_rdData = pfxValue;
        end
        APR_SEL_NONE: begin
          next_rdData = `APR_RD_RESET;
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= `APR_RD_RESET;
    end else begin
      rdData <= next_rdData;
    end
  end

  // Execution-unit view group.
  logic [`APR_DATA_W-1:0] next_accOut;
  logic next_accOutValid;

  // The selected accumulator is presented one cycle after the pointer and any
  // write settle; the core pays that cycle to keep every output on a flop.
  // A pointer to an accumulator held elsewhere gives zero with valid low, so the
  // bank can combine the views of its parts with a plain OR.
  always_comb begin
    next_accOut = `APR_ACC_RESET;
    next_accOutValid = 1'b0;
    unique case (decodePtr(alu.accPtr))
      APR_SEL_ACC2: begin
        next_accOut = next_acc2;
        next_accOutValid = 1'b1;
      end
      APR_SEL_ACC3: begin
        next_accOut = next_acc3;
        next_accOutValid = 1'b1;
      end
      default: begin
        next_accOut = `APR_ACC_RESET;
        next_accOutValid = 1'b0;
      end
    endcase
  end

  // Execution-unit view registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accOut <= `APR_ACC_RESET;
      accOutValid <= 1'b0;
    end else begin
      accOut <= next_accOut;
      accOutValid <= next_accOutValid;
    end
  end

  // Mirror group: plain copies of the register contents for the core datapath.
  logic [`APR_DATA_W-1:0] next_acc2Value;
  logic [`APR_DATA_W-1:0] next_acc3Value;
  logic [`APR_PFX_LO_MSB:0] next_pfxHigh;

  // The mirrors track the next values so that they match the registers in the
  // same cycle. The prefix byte is offered one cycle late, armed or live alike;
  // a consumer must qualify it with pfxActive, which is what limits its use to
  // a single instruction.
  always_comb begin
    next_acc2Value = next_acc2;
    next_acc3Value = next_acc3;
    next_pfxHigh = pfxValue[`APR_PFX_LO_MSB:0];
  end

  // Mirror registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc2Value <= `APR_ACC_RESET;
      acc3Value <= `APR_ACC_RESET;
      pfxHigh <= `APR_PFX_BYTE_RESET;
    end else begin
      acc2Value <= next_acc2Value;
      acc3Value <= next_acc3Value;
      pfxHigh <= next_pfxHigh;
    end
  end

endmodule

`default_nettype wire

// *** inc/apr_params.svh ***
`ifndef APR_PARAMS_SVH
`define APR_PARAMS_SVH

// Register bus shape.
`define APR_ADDR_W 8
`define APR_DATA_W 16
`define APR_PTR_W 4

// Register space: address is {module, subindex}.
`define APR_MOD_MSB 7
`define APR_MOD_LSB 4
`define APR_SUB_MSB 3
`define APR_SUB_LSB 0
`define APR_MOD_ACC 4'h9
`define APR_MOD_PFX 4'hB
`define APR_SUB_ACC2 4'h2
`define APR_SUB_ACC3 4'h3
`define APR_SUB_PFX_MAX 4'h7

// Accumulator pointer codes that select the two accumulators held here.
`define APR_PTR_ACC2 4'h2
`define APR_PTR_ACC3 4'h3

// Reset values.
`define APR_ACC_RESET 16'h0000
`define APR_PFX_RESET 16'h0000
`define APR_PFX_BYTE_RESET 8'h00
`define APR_PFX_EXT_RESET 3'h0
`define APR_RD_RESET 16'h0000

// Prefix field layout.
`define APR_PFX_LO_MSB 7
`define APR_PFX_HI_ZERO 8'h00
`define APR_PFX_EXT_MSB 2

`endif

// *** inc/apr_pkg.sv ***
`include "apr_params.svh"

package apr_pkg;

  // One register bus request, as the core presents it in a single cycle.
  typedef struct packed {
    logic [`APR_ADDR_W-1:0] addr;
    logic [`APR_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } apr_bus_req_t;

  // Execution-unit side: pointer, result write-back and instruction boundary.
  typedef struct packed {
    logic [`APR_PTR_W-1:0] accPtr;
    logic resultWe;
    logic [`APR_DATA_W-1:0] result;
    logic instrDone;
  } apr_alu_t;

  // Prefix life cycle, one-hot.
  typedef enum logic [2:0] {
    APR_PFX_IDLE = 3'b001,
    APR_PFX_ARMED = 3'b010,
    APR_PFX_LIVE = 3'b100
  } apr_pfx_state_t;

  // Decoded register target, one-hot.
  typedef enum logic [3:0] {
    APR_SEL_NONE = 4'b0001,
    APR_SEL_ACC2 = 4'b0010,
    APR_SEL_ACC3 = 4'b0100,
    APR_SEL_PFX = 4'b1000
  } apr_sel_t;

endpackage

// *** verilog/apr_prefix_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module apr_prefix_unit (
  input wire logic sys_clk, // Core clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic loadEn, // One-cycle load of the prefix.
  input wire logic [`APR_DATA_W-1:0] loadData, // Value being written.
  input wire logic [`APR_PFX_EXT_MSB:0] loadSub, // Subindex used for the load.
  input wire logic instrDone, // Pulse at the end of each instruction.
  output logic [`APR_DATA_W-1:0] pfxValue, // Register view, upper byte zero.
  output logic pfxActive, // Prefix applies to the current instruction.
  output logic [`APR_PFX_EXT_MSB:0] pfxExt // Index extension bits of the load.
);
  import apr_pkg::*;

  apr_pfx_state_t state, next_state;
  logic [`APR_PFX_LO_MSB:0] pfxByte, next_pfxByte;
  logic [`APR_PFX_EXT_MSB:0] extBits, next_extBits;

  // A load made during one instruction becomes live when that instruction ends,
  // and is wiped when the following one ends, so it serves exactly one instruction.
  always_comb begin
    next_state = state;
    next_pfxByte = pfxByte;
    next_extBits = extBits;
    if (loadEn) begin
      next_pfxByte = loadData[`APR_PFX_LO_MSB:0];
      next_extBits = loadSub;
      next_state = instrDone ? APR_PFX_LIVE : APR_PFX_ARMED;
    end else if (instrDone) begin
      unique case (state)
        APR_PFX_ARMED: begin
          next_state = APR_PFX_LIVE;
        end
        APR_PFX_LIVE: begin
          next_state = APR_PFX_IDLE;
          next_pfxByte = `APR_PFX_BYTE_RESET;
          next_extBits = `APR_PFX_EXT_RESET;
        end
        APR_PFX_IDLE: begin
          next_state = APR_PFX_IDLE;
        end
        default: begin
          // A corrupted code falls back to a cleared prefix.
          next_state = APR_PFX_IDLE;
          next_pfxByte = `APR_PFX_BYTE_RESET;
          next_extBits = `APR_PFX_EXT_RESET;
        end
      endcase
    end
  end

  // Prefix state registers; all clear on reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= APR_PFX_IDLE;
      pfxByte <= `APR_PFX_BYTE_RESET;
      extBits <= `APR_PFX_EXT_RESET;
    end else begin
      state <= next_state;
      pfxByte <= next_pfxByte;
      extBits <= next_extBits;
    end
  end

  // Upper byte is reserved and never stored, so it always reads zero.
  assign pfxValue = {`APR_PFX_HI_ZERO, pfxByte};
  // The live bit of the one-hot code is itself a flop, so the output needs no decode.
  assign pfxActive = state[2];
  assign pfxExt = extBits;

endmodule

`default_nettype wire

// *** tb/apr_regs_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module apr_regs_monitor (
  input wire logic sys_clk, // Core clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire apr_pkg::apr_bus_req_t busReq, // Register bus request.
  input wire logic [`APR_DATA_W-1:0] rdData, // Read data.
  input wire apr_pkg::apr_alu_t alu, // Execution unit port.
  input wire logic [`APR_DATA_W-1:0] accOut, // Selected accumulator.
  input wire logic accOutValid, // Pointer hit an accumulator here.
  input wire logic [`APR_DATA_W-1:0] acc2Value, // Second accumulator.
  input wire logic [`APR_DATA_W-1:0] acc3Value, // Third accumulator.
  input wire logic [`APR_PFX_LO_MSB:0] pfxHigh, // Prefix byte, one cycle late.
  input wire logic pfxActive, // Prefix live.
  input wire logic [`APR_PFX_EXT_MSB:0] pfxExt // Extension bits.
);
  import apr_pkg::*;
  logic pfxWr;

  // A prefix write is any write to module 0Bh with subindex 0 to 7.
  assign pfxWr = busReq.wr && busReq.addr[7:3] == 5'h16;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A bus write to the same accumulator wins, so those cycles are excluded.
  acc2_alu_a: assert property (alu.resultWe && alu.accPtr == 4'h2 && !(busReq.wr && busReq.addr == 8'h92)
    |=> acc2Value == $past(alu.result) && accOut == acc2Value && accOutValid) else $error("acc2 result lost");
  acc3_alu_a: assert property (alu.resultWe && alu.accPtr == 4'h3 && !(busReq.wr && busReq.addr == 8'h93)
    |=> acc3Value == $past(alu.result) && accOut == acc3Value && accOutValid) else $error("acc3 result lost");
  acc_hold_a: assert property (alu.resultWe && alu.accPtr[3:1] != 3'h1 && !busReq.wr
    |=> $stable(acc2Value) && $stable(acc3Value) && !accOutValid) else $error("stray result write");
  acc3_bus_a: assert property (busReq.wr && busReq.addr == 8'h93
    |=> acc3Value == $past(busReq.wdata)) else $error("acc3 bus write lost");
  pfx_store_a: assert property (pfxWr && !alu.instrDone ##1 !pfxWr
    |=> pfxHigh == $past(busReq.wdata[7:0], 2)) else $error("prefix byte lost");
  pfx_ext_a: assert property (pfxWr
    |=> pfxExt == $past(busReq.addr[2:0])) else $error("prefix ext wrong");
  pfx_live_a: assert property (pfxWr && !alu.instrDone ##1 alu.instrDone && !pfxWr
    |=> pfxActive) else $error("prefix not live");
  pfx_clear_a: assert property (pfxActive && alu.instrDone && !pfxWr
    |=> !pfxActive && pfxExt == 3'h0) else $error("prefix not cleared");
  pfx_hi_zero_a: assert property (busReq.rd && busReq.addr[7:4] == 4'hB
    |=> rdData[15:8] == 8'h00) else $error("prefix upper byte set");
  // Only a prefix that ran out is spent; a rewrite as it ends keeps it live with the new byte.
  pfx_gone_a: assert property ($past(pfxActive && alu.instrDone && !pfxWr)
    && busReq.rd && busReq.addr[7:4] == 4'hB |=> rdData == 16'h0000) else $error("spent prefix nonzero");
endmodule

bind apr_regs apr_regs_monitor mon_u (.sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
  .alu(alu), .accOut(accOut), .accOutValid(accOutValid), .acc2Value(acc2Value), .acc3Value(acc3Value),
  .pfxHigh(pfxHigh), .pfxActive(pfxActive), .pfxExt(pfxExt));
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "apr_params.svh"

module testbench;
  import apr_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  apr_bus_req_t busReq = '0;
  apr_alu_t alu = '0;
  logic [15:0] rdData, accOut, acc2Value, acc3Value, m2, m3, rdE, accE;
  logic [7:0] pfxHigh, pb, hiE;
  logic [2:0] pfxExt, pe;
  logic accOutValid, pfxActive, valE;
  int st;
  int errors = 0;
  int total_checks = 0;

  apr_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData), .alu(alu),
    .accOut(accOut), .accOutValid(accOutValid), .acc2Value(acc2Value), .acc3Value(acc3Value),
    .pfxHigh(pfxHigh), .pfxActive(pfxActive), .pfxExt(pfxExt));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] p, input logic we, input logic [15:0] res, input logic dn);
    @(posedge sys_clk);
    busReq <= '{addr: a, wdata: d, wr: w, rd: r};
    alu <= '{accPtr: p, resultWe: we, result: res, instrDone: dn};
  endtask

  task automatic step(input logic dn);
    drive(1'b0, 1'b0, 8'h00, 16'h0000, 4'h0, 1'b0, 16'h0000, dn);
  endtask

  // Random traffic; address class and strobe are drawn apart so every register
  // sees both reads and writes; write and read never share a cycle.
  task automatic rand_cycle;
    logic [7:0] a;
    logic [3:0] op;
    op = 4'($urandom);
    a = 8'($urandom);
    case (op[1:0])
      2'h0: a = 8'h92;
      2'h1: a = 8'h93;
      2'h2: a = {5'h16, a[2:0]};
      default: ;
    endcase
    drive(op[3:2] == 2'h1, op[3:2] == 2'h2, a, 16'($urandom), 4'($urandom), 1'($urandom), 16'($urandom),
          $urandom % 3 == 0);
  endtask

  // Reference model; it samples inputs at the same edge as the design.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {m2, m3, pb, pe, rdE, hiE, accE, valE} = '0;
      st = 0;
    end else begin
      hiE = pb;
      rdE = '0;
      if (busReq.rd && busReq.addr == 8'h92) rdE = m2;
      if (busReq.rd && busReq.addr == 8'h93) rdE = m3;
      if (busReq.rd && busReq.addr[7:3] == 5'h16) rdE = {8'h00, pb};
      if (alu.instrDone && st == 2) begin
        {pb, pe} = '0;
        st = 0;
      end else if (alu.instrDone && st == 1) st = 2;
      if (alu.resultWe && alu.accPtr == 4'h2) m2 = alu.result;
      if (alu.resultWe && alu.accPtr == 4'h3) m3 = alu.result;
      // Bus writes come last because they win over a same-cycle result.
      if (busReq.wr && busReq.addr == 8'h92) m2 = busReq.wdata;
      if (busReq.wr && busReq.addr == 8'h93) m3 = busReq.wdata;
      if (busReq.wr && busReq.addr[7:3] == 5'h16) begin
        pb = busReq.wdata[7:0];
        pe = busReq.addr[2:0];
        st = alu.instrDone ? 2 : 1;
      end
      valE = alu.accPtr == 4'h2 || alu.accPtr == 4'h3;
      accE = alu.accPtr == 4'h2 ? m2 : (alu.accPtr == 4'h3 ? m3 : 16'h0000);
    end
  end

  // Outputs are compared mid-cycle, well clear of the launching edge.
  always @(negedge sys_clk) begin
    if (rst_n) begin
      chk("rdData", rdE, rdData);
      chk("acc2Value", m2, acc2Value);
      chk("acc3Value", m3, acc3Value);
      chk("accOut", accE, accOut);
      chk("accOutValid", 16'(valE), 16'(accOutValid));
      chk("pfxHigh", 16'(hiE), 16'(pfxHigh));
      chk("pfxActive", 16'(st == 2), 16'(pfxActive));
      chk("pfxExt", 16'(pe), 16'(pfxExt));
    end
  end

  // The run needs about 4000 cycles; twice that means a hang.
  initial begin
    #320000;
    errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(95));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Load a prefix, read it, let two instructions end, then read it spent.
    drive(1'b1, 1'b0, 8'hB5, 16'h12AB, 4'h0, 1'b0, 16'h0000, 1'b0);
    drive(1'b0, 1'b1, 8'hB5, 16'h0000, 4'h0, 1'b0, 16'h0000, 1'b0);
    step(1'b1);
    step(1'b0);
    step(1'b1);
    drive(1'b0, 1'b1, 8'hB0, 16'h0000, 4'h0, 1'b0, 16'h0000, 1'b0);
    step(1'b0);
    repeat (3000) rand_cycle();
    // A reset in mid-run must clear everything again.
    step(1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk("acc3Value", 16'h0000, acc3Value);
    chk("pfxHigh", 16'h0000, 16'(pfxHigh));
    repeat (1000) rand_cycle();
    end_of_test();
  end
endmodule
`default_nettype wire
